// ===== hw/emph_top.sv
/*
  Encoder position hold, sixteen-section absolute positioning and index origin.
  Assumes all inputs synchronous to REF_CLK_I, an AHB-Lite master with single
  word transfers, and one encoder step pulse per count on ENC_STEP_I.
  // Function
  // - Slow plus zero-hold captures and holds position.
  // - Mode 0 enters hold below minimum frequency.
  // - Switch input turns select bits into positions.
  // - Mode 1 waits index; origin index plus offset.
  // - Index bias reads position minus index position.
  // - Bias reads 9999 before first index.
  // - Section selects accepted only while gate high.
  // - Section targets are absolute from origin.
  // - Target is rotations times PPR plus pulses.
  // - Positive error forward, negative error reverse.
  // - Encoder type codes zero to four.
  // - Generic encoder starts with full magnetizing current.
  // - Mode 0 without stored angle starts zero.
  // - Sine feedback blocks all position modes.
  // - Card not matching type raises fault.
  // - Type change needs retune else fault.
  // - Section counts clamp to plus minus 9999.
  // - Move speed limited to position maximum.
  // - Select bits one to four are inputs.
*/
`timescale 1ns/1ps
module emph_top
  import emph_pkg::*;
(
  input  wire logic        REF_CLK_I,    // Clock, 10 MHz.
  input  wire logic        RST_N_I,      // Synchronous reset, active low.
  input  wire logic        HSEL_I,       // AHB slave select.
  input  wire logic [31:0] HADDR_I,      // AHB address.
  input  wire logic [1:0]  HTRANS_I,     // AHB transfer type.
  input  wire logic        HWRITE_I,     // AHB write.
  input  wire logic [2:0]  HSIZE_I,      // AHB size, word only.
  input  wire logic [31:0] HWDATA_I,     // AHB write data.
  input  wire logic        HREADY_I,     // AHB bus ready.
  output logic [31:0]      HRDATA_O,     // AHB read data.
  output logic             HREADYOUT_O,  // AHB slave ready.
  output logic             HRESP_O,      // AHB response, always OKAY.
  input  wire logic        RUN_I,        // Run command.
  input  wire logic        ZERO_HOLD_I,  // Zero-hold command.
  input  wire logic        POS_SWITCH_I, // Speed/position switch.
  input  wire logic        POS_GATE_I,   // Position command gate.
  input  wire logic [3:0]  SEL_I,        // Select bits 1 to 4.
  input  wire logic        ENC_STEP_I,   // One encoder count.
  input  wire logic        ENC_DIR_I,    // Count direction, high up.
  input  wire logic        ENC_INDEX_I,  // Index pulse.
  input  wire logic [15:0] OUT_FREQ_I,   // Output frequency, 0.1 Hz.
  input  wire logic [1:0]  CARD_TYPE_I,  // Installed feedback card.
  output logic             POS_MODE_O,   // Position hold active.
  output logic             FWD_O,        // Drive forward.
  output logic             REV_O,        // Drive reverse.
  output logic [15:0]      FREQ_LIM_O,   // Move frequency limit.
  output logic [7:0]       START_CUR_O,  // Start current, percent.
  output logic             ZERO_ANGLE_O, // Start from 0 degrees.
  output logic             CARD_FLT_O,   // Card mismatch fault.
  output logic             REALIGN_FLT_O // Realign needed fault.
);
  // Clamp a signed count into the section range.
  function automatic logic [15:0] clamp_cnt(input logic [15:0] v);
    if ($signed(v) > $signed(SECT_LIM)) begin
      return SECT_LIM;
    end else if ($signed(v) < -$signed(SECT_LIM)) begin
      return 16'(-$signed(SECT_LIM));
    end
    return v;
  endfunction

  // Clamp an unsigned value into a range.
  function automatic logic [15:0] clamp_u(input logic [15:0] v, lo, hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Section offset from origin in encoder counts.
  function automatic logic [31:0] sect_cnt(input emph_sect_t s, input logic [15:0] ppr);
    logic signed [33:0] p;
    p = 34'($signed(s.rot) * $signed({1'b0, ppr})) + 34'($signed(s.pls));
    return p[31:0];
  endfunction

  logic [7:0]  addr_ff;
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic        mode_ff;
  logic [2:0]  enc_ff;
  logic        dir_inv_ff;
  logic [1:0]  pdm_ff;
  logic [15:0] ppr_ff;
  logic [15:0] minf_ff;
  logic [15:0] pmaxf_ff;
  logic [15:0] zofs_ff;
  logic        type_chg_ff;
  logic        angle_ok_ff;
  logic        run_q_ff;
  logic [31:0] pos_ff;
  logic [31:0] idx_pos_ff;
  logic        idx_seen_ff;
  logic [31:0] zbias_ff;
  logic [31:0] origin_ff;
  logic [31:0] target_ff;
  logic [3:0]  sel_ff;
  logic        use_sect_ff;
  emph_state_t state_ff;
  emph_sect_t  q_a;
  emph_sect_t  q_b;
  logic [31:0] rd_mux;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_sect;
  logic        slow;
  logic        allow;
  logic        keep;
  logic [1:0]  card_exp;

  // An address phase is taken only on a selected NONSEQ or SEQ with the bus ready.
  assign acc     = HSEL_I & HREADY_I & HTRANS_I[1];
  assign wr_ctrl = wr_pend_ff & (addr_ff == OFF_CTRL);
  assign wr_sect = wr_pend_ff & (addr_ff[7:6] == OFF_SECT[7:6]);

  // Address phase capture; reads get one wait state for the registered table.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      addr_ff     <= 8'h00;
      wr_pend_ff  <= 1'b0;
      rd_pend_ff  <= 1'b0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      wr_pend_ff  <= acc & HWRITE_I;
      rd_pend_ff  <= acc & ~HWRITE_I;
      HREADYOUT_O <= ~(acc & ~HWRITE_I);
      HRESP_O     <= 1'b0;
      if (acc) begin
        addr_ff <= {HADDR_I[7:2], 2'b00};
      end
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ff[7:6] == OFF_SECT[7:6]) begin
      rd_mux = q_a;
    end else begin
      unique case (addr_ff)
        OFF_CTRL:  rd_mux = {25'h0, pdm_ff, dir_inv_ff, enc_ff, mode_ff};
        OFF_PPR:   rd_mux = {16'h0, ppr_ff};
        OFF_MINF:  rd_mux = {16'h0, minf_ff};
        OFF_PMAXF: rd_mux = {16'h0, pmaxf_ff};
        OFF_ZOFS:  rd_mux = {16'h0, zofs_ff};
        OFF_STAT:  rd_mux = {22'h0, REALIGN_FLT_O, CARD_FLT_O, idx_seen_ff,
                             use_sect_ff, sel_ff, 2'(state_ff)};
        OFF_POS:   rd_mux = pos_ff;
        OFF_ZBIAS: rd_mux = zbias_ff;
        OFF_TUNE:  rd_mux = {31'h0, type_chg_ff};
        default:   rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data are loaded during the wait state and then held.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (rd_pend_ff) begin
      HRDATA_O <= rd_mux;
    end
  end

  // Control register; codes above four are refused and the old type stays.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      mode_ff    <= 1'b0;
      enc_ff     <= ENC_RST;
      dir_inv_ff <= 1'b0;
      pdm_ff     <= 2'h0;
    end else if (wr_ctrl) begin
      mode_ff    <= HWDATA_I[CTL_MODE_BIT];
      dir_inv_ff <= HWDATA_I[CTL_DIR_BIT];
      pdm_ff     <= HWDATA_I[CTL_PDM_LSB +: 2];
      if (HWDATA_I[CTL_ENC_LSB +: 3] <= ENC_SINE) begin
        enc_ff <= HWDATA_I[CTL_ENC_LSB +: 3];
      end
    end
  end

  // Numeric settings; the maximum frequency and the index offset are held inside their legal ranges.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      ppr_ff   <= PPR_RST;
      minf_ff  <= MINF_RST;
      pmaxf_ff <= PMAXF_RST;
      zofs_ff  <= ZOFS_RST;
    end else if (wr_pend_ff) begin
      if (addr_ff == OFF_PPR) begin
        ppr_ff <= HWDATA_I[15:0];
      end
      if (addr_ff == OFF_MINF) begin
        minf_ff <= HWDATA_I[15:0];
      end
      if (addr_ff == OFF_PMAXF) begin
        pmaxf_ff <= clamp_u(HWDATA_I[15:0], PMAXF_MIN, PMAXF_MAX);
      end
      if (addr_ff == OFF_ZOFS) begin
        zofs_ff <= clamp_u(HWDATA_I[15:0], 16'h0000, ZOFS_MAX);
      end
    end
  end

  // A type change stays pending until tuning is reported; a new change wins.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      type_chg_ff <= 1'b0;
    end else if (wr_ctrl && HWDATA_I[CTL_ENC_LSB +: 3] != enc_ff
                 && HWDATA_I[CTL_ENC_LSB +: 3] <= ENC_SINE) begin
      type_chg_ff <= 1'b1;
    end else if (wr_pend_ff && addr_ff == OFF_TUNE && HWDATA_I[0]) begin
      type_chg_ff <= 1'b0;
    end
  end

  // Fault outputs; running with a pending type change needs realignment.
  assign card_exp = (enc_ff == ENC_SINE) ? CARD_SINE : CARD_PULSE;
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      CARD_FLT_O    <= 1'b0;
      REALIGN_FLT_O <= 1'b0;
    end else begin
      CARD_FLT_O    <= (CARD_TYPE_I != card_exp);
      REALIGN_FLT_O <= type_chg_ff & RUN_I;
    end
  end

  // Section table; counts are clamped on the way in.
  emph_sect_mem #(
    .DEPTH(16)
  ) i_emph_sect_mem (
    .clk_i     (REF_CLK_I),
    .we_i      (wr_sect),
    .waddr_i   (addr_ff[5:2]),
    .wdata_i   ({clamp_cnt(HWDATA_I[31:16]), clamp_cnt(HWDATA_I[15:0])}),
    .raddr_a_i (HADDR_I[5:2]),
    .raddr_b_i (sel_ff),
    .q_a_o     (q_a),
    .q_b_o     (q_b)
  );

  // Shaft counter; the direction bit can be turned round by software.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      pos_ff <= 32'h0000_0000;
    end else if (ENC_STEP_I) begin
      pos_ff <= (ENC_DIR_I ^ dir_inv_ff) ? pos_ff + 32'h0000_0001
                                         : pos_ff - 32'h0000_0001;
    end
  end

  // Index capture and bias monitor; until the first index the bias reads 9999.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      idx_pos_ff  <= 32'h0000_0000;
      idx_seen_ff <= 1'b0;
      zbias_ff    <= ZBIAS_NONE;
    end else begin
      if (ENC_INDEX_I) begin
        idx_pos_ff  <= pos_ff;
        idx_seen_ff <= 1'b1;
      end
      zbias_ff <= idx_seen_ff ? pos_ff - idx_pos_ff : ZBIAS_NONE;
    end
  end

  // Sine feedback never lets a position mode start or continue.
  assign slow  = OUT_FREQ_I < minf_ff;
  assign keep  = RUN_I & ZERO_HOLD_I & (enc_ff != ENC_SINE);
  assign allow = keep & slow;

  // Hold state machine and origin capture.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      state_ff  <= ST_RUN;
      origin_ff <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        ST_RUN: begin
          if (allow && !mode_ff) begin
            state_ff  <= ST_HOLD;
            origin_ff <= pos_ff;
          end else if (allow) begin
            state_ff <= ST_WAITZ;
          end
        end
        ST_WAITZ: begin
          if (!keep) begin
            state_ff <= ST_RUN;
          end else if (ENC_INDEX_I && slow) begin
            state_ff  <= ST_HOLD;
            origin_ff <= pos_ff + {16'h0000, zofs_ff};
          end
        end
        ST_HOLD: begin
          if (!keep) begin
            state_ff <= ST_RUN;
          end
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  // Section selection is taken only in hold with switch and gate both high.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      sel_ff      <= 4'h0;
      use_sect_ff <= 1'b0;
    end else if (state_ff != ST_HOLD) begin
      use_sect_ff <= 1'b0;
    end else if (POS_SWITCH_I && POS_GATE_I) begin
      sel_ff      <= SEL_I;
      use_sect_ff <= 1'b1;
    end
  end

  // Target is absolute from the origin; the table read adds one cycle.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      target_ff <= 32'h0000_0000;
    end else if (state_ff != ST_HOLD) begin
      target_ff <= pos_ff;
    end else begin
      target_ff <= use_sect_ff ? origin_ff + sect_cnt(q_b, ppr_ff) : origin_ff;
    end
  end

  // Direction and speed limit of the move, both held at zero outside hold.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      POS_MODE_O <= 1'b0;
      FWD_O      <= 1'b0;
      REV_O      <= 1'b0;
      FREQ_LIM_O <= 16'h0000;
    end else begin
      POS_MODE_O <= (state_ff == ST_HOLD);
      FWD_O      <= (state_ff == ST_HOLD) && $signed(target_ff) > $signed(pos_ff);
      REV_O      <= (state_ff == ST_HOLD) && $signed(target_ff) < $signed(pos_ff);
      FREQ_LIM_O <= (state_ff == ST_HOLD) ? pmaxf_ff : 16'h0000;
    end
  end

  // A stop angle exists only after one stop since power-up.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      run_q_ff    <= 1'b0;
      angle_ok_ff <= 1'b0;
    end else begin
      run_q_ff <= RUN_I;
      if (run_q_ff && !RUN_I) begin
        angle_ok_ff <= 1'b1;
      end
    end
  end

  // Start behaviour of the generic incremental encoder.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      START_CUR_O  <= 8'h00;
      ZERO_ANGLE_O <= 1'b0;
    end else begin
      START_CUR_O  <= (enc_ff == ENC_GENERIC) ? START_PCT : 8'h00;
      ZERO_ANGLE_O <= (enc_ff == ENC_GENERIC) && pdm_ff == 2'h0 && !angle_ok_ff;
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  chk_hold_capture: assert property (
    (state_ff == ST_RUN && allow && !mode_ff) |=> origin_ff == $past(pos_ff))
    else $error("origin not captured");
  chk_mode0_entry: assert property (
    (state_ff == ST_RUN && allow && !mode_ff) |=> ##1 POS_MODE_O)
    else $error("mode 0 hold not entered");
  chk_index_wait: assert property (
    (state_ff == ST_WAITZ && !ENC_INDEX_I) |=> state_ff != ST_HOLD)
    else $error("hold entered without index");
  chk_bias_value: assert property (
    (idx_seen_ff && !ENC_INDEX_I) |=> zbias_ff == $past(pos_ff) - idx_pos_ff)
    else $error("bias wrong");
  chk_bias_none: assert property (
    !idx_seen_ff |=> zbias_ff == ZBIAS_NONE)
    else $error("bias not 9999 before index");
  chk_gate_ignore: assert property (
    !POS_GATE_I |=> $stable(sel_ff))
    else $error("selection taken without gate");
  chk_move_dir: assert property (
    (state_ff == ST_HOLD && $signed(target_ff) > $signed(pos_ff)) |=> FWD_O && !REV_O)
    else $error("forward move not driven");
  chk_sine_block: assert property (
    enc_ff == ENC_SINE |=> state_ff == ST_RUN)
    else $error("position mode with sine feedback");
  chk_card_fault: assert property (
    (CARD_TYPE_I != card_exp) |=> CARD_FLT_O)
    else $error("card mismatch not flagged");
  chk_realign_flt: assert property (
    (type_chg_ff && RUN_I) |=> REALIGN_FLT_O)
    else $error("realign fault missing");
  cov_mode0_hold: cover property (state_ff == ST_RUN ##1 state_ff == ST_HOLD);
  cov_index_hold: cover property (state_ff == ST_WAITZ ##1 state_ff == ST_HOLD);
  cov_section_mv: cover property (use_sect_ff && FWD_O);
endmodule // emph_top

// ===== hw/emph_pkg.sv
/*
  Shared constants and types of the encoder position-hold block.
  Assumes a 32-bit AHB-Lite register bus and word-aligned registers.
*/
package emph_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_PPR   = 8'h04;
  localparam logic [7:0] OFF_MINF  = 8'h08;
  localparam logic [7:0] OFF_PMAXF = 8'h0C;
  localparam logic [7:0] OFF_ZOFS  = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h14;
  localparam logic [7:0] OFF_POS   = 8'h18;
  localparam logic [7:0] OFF_ZBIAS = 8'h1C;
  localparam logic [7:0] OFF_TUNE  = 8'h20;
  localparam logic [7:0] OFF_SECT  = 8'h40;
  // Control field positions.
  localparam int CTL_MODE_BIT = 0;
  localparam int CTL_ENC_LSB  = 1;
  localparam int CTL_DIR_BIT  = 4;
  localparam int CTL_PDM_LSB  = 5;
  // Reset values.
  localparam logic [2:0]  ENC_RST   = 3'h3;
  localparam logic [15:0] PPR_RST   = 16'h0400;
  localparam logic [15:0] MINF_RST  = 16'h0005;
  localparam logic [15:0] PMAXF_RST = 16'h0064;
  localparam logic [15:0] ZOFS_RST  = 16'h0000;
  // Encoder type codes and limits.
  localparam logic [2:0]  ENC_GENERIC = 3'h3;
  localparam logic [2:0]  ENC_SINE    = 3'h4;
  localparam logic [1:0]  CARD_PULSE  = 2'h1;
  localparam logic [1:0]  CARD_SINE   = 2'h2;
  localparam logic [15:0] SECT_LIM    = 16'h270F;
  localparam logic [15:0] ZOFS_MAX    = 16'h270F;
  localparam logic [15:0] PMAXF_MIN   = 16'h0001;
  localparam logic [15:0] PMAXF_MAX   = 16'h03E8;
  localparam logic [31:0] ZBIAS_NONE  = 32'h0000_270F;
  localparam logic [7:0]  START_PCT   = 8'h64;
  // Hold state machine.
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_WAITZ = 2'b01,
    ST_HOLD  = 2'b11
  } emph_state_t;
  // One section entry: signed rotations and signed pulses.
  typedef struct packed {
    logic signed [15:0] rot;
    logic signed [15:0] pls;
  } emph_sect_t;
endpackage

// ===== hw/emph_sect_mem.sv
/*
  Sixteen-entry section table with one write port and two registered read ports.
  Assumes a single clock; read data appear one edge after the address.
*/
`timescale 1ns/1ps
module emph_sect_mem
  import emph_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic       clk_i,   // Clock.
  input  wire logic       we_i,    // Write strobe.
  input  wire logic [3:0] waddr_i, // Write index.
  input  wire emph_sect_t wdata_i, // Write entry.
  input  wire logic [3:0] raddr_a_i, // Bus read index.
  input  wire logic [3:0] raddr_b_i, // Section read index.
  output emph_sect_t      q_a_o,   // Bus read data.
  output emph_sect_t      q_b_o    // Section read data.
);
  emph_sect_t mem [DEPTH];

  // Table contents; no reset so the storage maps onto plain RAM.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Both read ports are registered.
  always_ff @(posedge clk_i) begin
    q_a_o <= mem[raddr_a_i];
    q_b_o <= mem[raddr_b_i];
  end
endmodule // emph_sect_mem

// ===== tb/emph_enc_model.sv
/*
  Behavioural shaft encoder and motor for the position-hold bench.
  Assumes the drive requests are registered levels on the same clock as the counts.
*/
`timescale 1ns/1ps
module emph_enc_model #(
  parameter int PPR = 1024 // Counts per revolution.
) (
  input  wire logic clk_i,   // Clock.
  input  wire logic rst_n_i, // Synchronous reset, active low.
  input  wire logic fwd_i,   // Drive forward.
  input  wire logic rev_i,   // Drive reverse.
  input  wire logic man_i,   // Hand turn, always upward.
  input  wire logic slow_i,  // Slow shaft.
  output logic      step_o,  // One count.
  output logic      dir_o,   // Count up when high.
  output logic      index_o  // Index mark.
);
  logic [3:0] cnt_ff;
  int         ang_ff;
  int         nxt_ang;
  logic       up;
  logic       go;

  // Reverse drive wins; a hand turn only goes upward.
  assign up      = !rev_i;
  assign go      = fwd_i | rev_i | man_i;
  assign nxt_ang = up ? ang_ff + 1 : ang_ff - 1;

  // A count every fourth or eighth cycle, so the shaft never outruns the registered drive.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_ff  <= 4'h0;
      ang_ff  <= 0;
      step_o  <= 1'b0;
      dir_o   <= 1'b0;
      index_o <= 1'b0;
    end else begin
      step_o  <= 1'b0;
      index_o <= 1'b0;
      dir_o   <= ~dir_o; // Direction is meaningless between counts, so it keeps changing.
      cnt_ff  <= cnt_ff + 4'h1;
      if (cnt_ff >= (slow_i ? 4'h7 : 4'h3)) begin
        cnt_ff <= 4'h0;
        if (go) begin
          step_o  <= 1'b1;
          dir_o   <= up;
          ang_ff  <= nxt_ang;
          index_o <= (nxt_ang % PPR) == 0;
        end
      end
    end
  end
endmodule // emph_enc_model

// ===== tb/tb_emph_top.sv
/*
  Self-checking bench for the position-hold block: AHB register tasks and drive scenarios.
  Assumes the encoder model is compiled first and a 10 MHz clock.
*/
`timescale 1ns/1ps
module tb_emph_top
  import emph_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n, hsel, hwrite, hready, hresp, run, zh, psw, gate, man, slow;
  logic        step, edir, eidx, fwd, rev, pmode, zang, cflt, rflt, saw_f, saw_r;
  logic [31:0] haddr, hwdata, hrdata, rd, org;
  logic [1:0]  htrans, card;
  logic [2:0]  hsize;
  logic [3:0]  sel;
  logic [15:0] freq, flim;
  logic [7:0]  scur;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [7:0]  r_off[8] = '{OFF_CTRL, OFF_PPR, OFF_MINF, OFF_PMAXF, OFF_ZOFS, OFF_ZBIAS,
                            OFF_TUNE, 8'h30};
  logic [31:0] r_val[8] = '{32'h0000_0006, {16'h0000, PPR_RST}, {16'h0000, MINF_RST},
                            {16'h0000, PMAXF_RST}, {16'h0000, ZOFS_RST}, ZBIAS_NONE,
                            32'h0000_0000, 32'h0000_0000};
  logic [3:0]  s_tab[4] = '{4'h1, 4'h2, 4'h8, 4'h0};
  int          d_tab[4] = '{512, -768, 1024, 0};

  // Free-running 100 ns clock.
  always #50 clk = ~clk;

  // The slave's ready is the bus's ready.
  emph_top i_emph_top (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .RUN_I(run),
    .ZERO_HOLD_I(zh), .POS_SWITCH_I(psw), .POS_GATE_I(gate), .SEL_I(sel),
    .ENC_STEP_I(step), .ENC_DIR_I(edir), .ENC_INDEX_I(eidx), .OUT_FREQ_I(freq),
    .CARD_TYPE_I(card), .POS_MODE_O(pmode), .FWD_O(fwd), .REV_O(rev), .FREQ_LIM_O(flim),
    .START_CUR_O(scur), .ZERO_ANGLE_O(zang), .CARD_FLT_O(cflt), .REALIGN_FLT_O(rflt)
  );

  // The shaft follows the drive, or the bench's hand.
  emph_enc_model #(.PPR(1024)) i_emph_enc_model (
    .clk_i(clk), .rst_n_i(rst_n), .fwd_i(fwd), .rev_i(rev), .man_i(man), .slow_i(slow),
    .step_o(step), .dir_o(edir), .index_o(eidx)
  );

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // One single word transfer; read data are taken at the edge that ends the data phase.
  task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h00_0000, off};
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
    chk_bit(hresp, 1'b0, "response");
  endtask

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    ahb(1'b1, off, d, rd);
  endtask

  task automatic rdc(input logic [7:0] off, input logic [31:0] exp, input string what);
    ahb(1'b0, off, 32'h0000_0000, rd);
    chk_val(rd, exp, what);
  endtask

  task automatic wait_mode(input logic exp);
    for (int i = 0; i < 10000 && pmode !== exp; i++) @(posedge clk);
    chk_bit(pmode, exp, "hold mode");
  endtask

  // Waits until the drive has been quiet for twelve cycles, noting which ways it drove.
  task automatic settle();
    int q;
    q = 0;
    saw_f = 1'b0;
    saw_r = 1'b0;
    for (int i = 0; i < 20000 && q < 12; i++) begin
      @(posedge clk);
      saw_f = saw_f | fwd;
      saw_r = saw_r | rev;
      q = (fwd | rev) ? 0 : q + 1;
    end
    if (q < 12) begin
      num_errors++;
      $display("BAD %0t drive never settled", $time);
    end
  endtask

  task automatic man_steps(input int n);
    int k;
    k = 0;
    man <= 1'b1;
    while (k < n) begin
      @(posedge clk);
      if (step === 1'b1) k++;
    end
    man <= 1'b0;
  endtask

  // The gate drops while the select changes, so only the new section is taken.
  task automatic move(input logic [3:0] s, input logic [31:0] exp, input logic f);
    gate <= 1'b0;
    sel  <= s;
    @(posedge clk);
    gate <= 1'b1;
    settle();
    chk_bit(saw_f, f, "forward drive");
    chk_bit(saw_r, !f, "reverse drive");
    rdc(OFF_POS, exp, "section position");
  endtask

  task automatic give_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cuts a hang short; the scenarios need well under half of this.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      $display("BAD %0t run too long", $time);
      give_verdict();
    end
  end

  // Main sequence.
  initial begin
    {rst_n, hsel, hwrite, run, zh, psw, gate, man, slow} = '0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    hsize = 3'b010;
    sel = 4'h0;
    freq = 16'h000A;
    card = CARD_PULSE;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rdc(r_off[i], r_val[i], "reset value");
    chk_val({24'h00_0000, scur}, {24'h00_0000, START_PCT}, "start current");
    chk_bit(zang, 1'b1, "zero angle");
    chk_bit(cflt | rflt, 1'b0, "faults");
    wr(OFF_CTRL, 32'h0000_0026);
    rdc(OFF_CTRL, 32'h0000_0026, "pole mode");
    chk_bit(zang, 1'b0, "pole mode 1");
    wr(8'h30, 32'hFFFF_FFFF);
    rdc(8'h30, 32'h0000_0000, "unmapped");
    wr(OFF_PMAXF, 32'h0000_0000);
    rdc(OFF_PMAXF, {16'h0000, PMAXF_MIN}, "max freq low");
    wr(OFF_PMAXF, 32'h0000_07D0);
    rdc(OFF_PMAXF, {16'h0000, PMAXF_MAX}, "max freq high");
    wr(OFF_ZOFS, 32'h0000_2710);
    rdc(OFF_ZOFS, {16'h0000, ZOFS_MAX}, "offset");
    wr(OFF_SECT + 8'h3C, 32'hD8EF_2711);
    rdc(OFF_SECT + 8'h3C, 32'hD8F1_270F, "section clamp");
    // Every type code, then code 5, which must be ignored.
    for (int t = 0; t < 6; t++) begin
      wr(OFF_CTRL, 32'(t) << 1);
      rdc(OFF_CTRL, (t == 5 ? 32'h0000_0004 : 32'(t)) << 1, "encoder type");
      chk_val({24'h00_0000, scur}, {24'h00_0000, (t == 3) ? START_PCT : 8'h00}, "cur");
    end
    chk_bit(cflt, 1'b1, "card fault");
    card <= CARD_SINE;
    repeat (3) @(posedge clk);
    chk_bit(cflt, 1'b0, "card match");
    card <= CARD_PULSE;
    run <= 1'b1;
    zh <= 1'b1;
    freq <= 16'h0003;
    repeat (8) @(posedge clk);
    chk_bit(pmode, 1'b0, "sine hold");
    chk_bit(rflt, 1'b1, "realign set");
    rdc(OFF_TUNE, 32'h0000_0001, "tune pending");
    zh <= 1'b0;
    wr(OFF_CTRL, 32'h0000_0006);
    chk_bit(rflt, 1'b1, "realign kept");
    wr(OFF_TUNE, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk_bit(rflt, 1'b0, "realign cleared");
    chk_bit(zang, 1'b1, "zero angle run");
    run <= 1'b0;
    repeat (3) @(posedge clk);
    chk_bit(zang, 1'b0, "stop angle");
    // Mode 0 hold; a frequency equal to the minimum is not below it.
    freq <= 16'h0005;
    run <= 1'b1;
    @(posedge clk);
    zh <= 1'b1;
    repeat (8) @(posedge clk);
    chk_bit(pmode, 1'b0, "not slow");
    freq <= 16'h0003;
    wait_mode(1'b1);
    repeat (6) @(posedge clk);
    chk_val({16'h0000, flim}, {16'h0000, PMAXF_MAX}, "freq limit");
    chk_bit(fwd | rev, 1'b0, "held still");
    rdc(OFF_POS, 32'h0000_0000, "hold origin");
    org = 32'h0000_0000;
    wr(OFF_SECT, 32'h0000_0000);
    wr(OFF_SECT + 8'h04, 32'h0000_0200);
    wr(OFF_SECT + 8'h08, 32'hFFFF_0100);
    wr(OFF_SECT + 8'h20, 32'h0001_0000);
    psw <= 1'b1;
    sel <= 4'h1;
    repeat (10) @(posedge clk);
    chk_bit(fwd | rev, 1'b0, "ungated select");
    for (int i = 0; i < 4; i++) move(s_tab[i], org + 32'(d_tab[i]), i % 2 == 0);
    rdc(OFF_STAT, 32'h0000_00C3, "status");
    // Index origin with a slow shaft.
    {gate, psw, zh} <= 3'b000;
    wait_mode(1'b0);
    wr(OFF_ZOFS, 32'h0000_0064);
    wr(OFF_CTRL, 32'h0000_0007);
    slow <= 1'b1;
    zh <= 1'b1;
    repeat (8) @(posedge clk);
    chk_bit(pmode, 1'b0, "wait index");
    man <= 1'b1;
    wait_mode(1'b1);
    man <= 1'b0;
    settle();
    rdc(OFF_ZBIAS, 32'h0000_0064, "index origin");
    zh <= 1'b0;
    man_steps(10);
    repeat (4) @(posedge clk);
    rdc(OFF_ZBIAS, 32'h0000_006E, "index bias");
    wr(OFF_CTRL, 32'h0000_0016);
    ahb(1'b0, OFF_POS, 32'h0000_0000, org);
    man_steps(5);
    repeat (4) @(posedge clk);
    rdc(OFF_POS, org - 32'h0000_0005, "inverted count");
    give_verdict();
  end
endmodule // tb_emph_top
